// file: logic/adc_regs_pkg.sv
/*
 * Constants, field layouts and carrier types for the converter's
 * identification, status and run-command registers.
 * Assumes a serial frame decoder outside, on the link clock, that hands
 * over one register access at a time.
 */
// How it works
// - status bit 7 shows wire mode latched from chip select after reset
// - analog supply low flag resets to 1, set on undervoltage, write 1 clears
// - status bit 5 set by any reset or brownout, write 1 clears
// - link check error set blocks all writes except to status
// - link check error only set while enabled, write 1 clears
// - map check enabled and written check value mismatches sets bit 3
// - map check error clears on write 1 or check disable
// - bit 2 internal fault is read only, cleared only by reset
// - bit 1 refreshed each conversion end with saturation seen during it
// - bit 0 always inverse of data-ready pin, 1 means unread data
// - one-shot mode keeps new-data bit until next conversion starts
// - key 010110b in bits 7:2 with start and stop 0 resets device
// - reset key field always reads back zero
// - start begins conversions: one in one-shot, continuous in start/stop
// - start during a conversion abandons it and begins anew
// - synchronized mode ignores start and stop commands
// - start and stop both set together is no operation
// - stop halts after the running conversion completes, not cut short
// - start and stop clear themselves and read back zero
// - writes to 4h..Eh restart a running converter, never start idle one
// - three-wire mode falls back to four-wire when chip select goes high
`default_nettype none

package adc_regs_pkg;

   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [3:0] ADDR_IDENT = 4'h0;
   localparam logic [3:0] ADDR_REVISION = 4'h1;
   localparam logic [3:0] ADDR_FLAGS = 4'h2;
   localparam logic [3:0] ADDR_CMD = 4'h3;
   localparam logic [3:0] ADDR_CFG_LO = 4'h4;
   localparam logic [3:0] ADDR_CFG_HI = 4'he;
   localparam logic [3:0] ADDR_MAP_CHECK = 4'hf;

   // arbitrary identity values
   localparam logic [7:0] DEVICE_IDENTIFIER = 8'h5a;
   localparam logic [7:0] DIE_REVISION = 8'h00;

   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int FLAG_WIRE = 7;
   localparam int FLAG_ALV = 6;
   localparam int FLAG_RST = 5;
   localparam int FLAG_LINK = 4;
   localparam int FLAG_MAP = 3;
   localparam int FLAG_INT = 2;
   localparam int FLAG_SAT = 1;
   localparam int FLAG_NEW = 0;
   localparam int CMD_START = 1;
   localparam int CMD_STOP = 0;
   localparam logic [5:0] RESET_KEY = 6'b010110;

   localparam logic ALV_RESET = 1'b1;
   localparam logic RST_FLAG_RESET = 1'b1;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam logic [7:0] CONV_CYCLES = 8'h40;

   typedef enum logic [1:0] {
      MODE_START_STOP = 2'b00,
      MODE_ONE_SHOT = 2'b01,
      MODE_SYNC = 2'b10
   } run_mode_t;

   typedef enum logic {
      CONV_IDLE = 1'b0,
      CONV_RUN = 1'b1
   } conv_state_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [3:0] addr;
      logic [7:0] data;
   } link_req_t;

   typedef struct packed {
      logic write;
      logic [3:0] addr;
      logic [7:0] data;
   } cfg_wr_t;

endpackage : adc_regs_pkg

`default_nettype wire

// file: logic/adc_status_control_regs.sv
/*
 * Status and run-command register bank of the converter, with the
 * conversion sequencer that the commands steer.
 * Assumes link-side accesses arrive on link_clk_i one at a time and that
 * saturation and conversion-read events are core signals; supply monitors pass through core-side synchronisers.
 */
`default_nettype none

module adc_status_control_regs (
   // core clock and reset
   input wire logic core_clk_i,
   input wire logic srst_i,
   // link side
   input wire logic link_clk_i,
   input wire adc_regs_pkg::link_req_t link_req_i,
   input wire logic link_crc_err_i,
   output logic link_busy_o,
   output logic link_done_o,
   output logic [7:0] link_rdata_o,
   // pins and monitors
   input wire logic cs_n_i,
   input wire logic analog_low_i,
   input wire logic io_brownout_i,
   input wire logic regulator_fault_i,
   input wire logic internal_fault_i,
   // core datapath hooks
   input wire adc_regs_pkg::run_mode_t run_mode_i,
   input wire logic link_crc_en_i,
   input wire logic map_crc_en_i,
   input wire logic [7:0] map_crc_calc_i,
   input wire logic mod_sat_i,
   input wire logic sample_read_i,
   // outputs
   output logic new_sample_indicator_n_o,
   output logic converting_o,
   output logic conv_done_o,
   output logic sync_lost_o,
   output adc_regs_pkg::cfg_wr_t cfg_wr_o,
   output logic cfg_wr_valid_o
);
   import adc_regs_pkg::*;

   // ****************************************************************
   // link domain
   // ****************************************************************
   logic [1:0] lrst_sync_r;
   logic lrst;
   link_req_t hold_r;
   logic req_tgl_r;
   logic [2:0] ack_sync_r;
   logic crc_tgl_r;
   logic [7:0] rdata_r;
   logic ack_tgl_r;

   always_ff @(posedge link_clk_i) begin
      lrst_sync_r <= {lrst_sync_r[0], srst_i};
   end
   assign lrst = lrst_sync_r[1];

   // one access in flight; the next is dropped until the core answers
   always_ff @(posedge link_clk_i) begin
      if (lrst) begin
         hold_r <= '0;
         req_tgl_r <= 1'b0;
         link_busy_o <= 1'b0;
      end else if (link_req_i.valid && !link_busy_o) begin
         hold_r <= link_req_i;
         req_tgl_r <= ~req_tgl_r;
         link_busy_o <= 1'b1;
      end else if (ack_sync_r[2] != ack_sync_r[1]) begin
         link_busy_o <= 1'b0;
      end
   end

   always_ff @(posedge link_clk_i) begin
      if (lrst) begin
         ack_sync_r <= '0;
         link_done_o <= 1'b0;
         link_rdata_o <= '0;
      end else begin
         ack_sync_r <= {ack_sync_r[1:0], ack_tgl_r};
         link_done_o <= ack_sync_r[2] != ack_sync_r[1];
         if (ack_sync_r[2] != ack_sync_r[1]) begin
            link_rdata_o <= rdata_r;
         end
      end
   end

   always_ff @(posedge link_clk_i) begin
      if (lrst) begin
         crc_tgl_r <= 1'b0;
      end else if (link_crc_err_i) begin
         crc_tgl_r <= ~crc_tgl_r;
      end
   end

   // ****************************************************************
   // core-side synchronisers
   // ****************************************************************
   logic [2:0] req_sync_r;
   logic [2:0] crc_sync_r;
   logic [1:0] cs_sync_r;
   logic [1:0] alv_sync_r;
   logic [1:0] bo_sync_r;
   logic [1:0] reg_sync_r;
   logic [1:0] int_sync_r;
   logic req_ev;
   logic crc_ev;

   always_ff @(posedge core_clk_i) begin
      req_sync_r <= {req_sync_r[1:0], req_tgl_r};
      crc_sync_r <= {crc_sync_r[1:0], crc_tgl_r};
      cs_sync_r <= {cs_sync_r[0], cs_n_i};
      alv_sync_r <= {alv_sync_r[0], analog_low_i};
      bo_sync_r <= {bo_sync_r[0], io_brownout_i};
      reg_sync_r <= {reg_sync_r[0], regulator_fault_i};
      int_sync_r <= {int_sync_r[0], internal_fault_i};
   end
   assign req_ev = req_sync_r[2] != req_sync_r[1];
   assign crc_ev = crc_sync_r[2] != crc_sync_r[1];

   // ****************************************************************
   // access decode
   // ****************************************************************
   logic rst;
   logic soft_rst_r;
   logic link_err_r;
   logic wr_ok;
   logic wr_flags;
   logic wr_cmd;
   logic [7:0] wd;
   logic cmd_start;
   logic cmd_stop;

   assign rst = srst_i | soft_rst_r;
   assign wd = hold_r.data;
   // hold_r is stable while req_tgl_r is in flight, so it is safe here
   assign wr_ok = req_ev && hold_r.write
                  && (!link_err_r || hold_r.addr == ADDR_FLAGS);
   assign wr_flags = wr_ok && hold_r.addr == ADDR_FLAGS;
   assign wr_cmd = wr_ok && hold_r.addr == ADDR_CMD;
   // both bits set, or synchronized mode, gives no command
   assign cmd_start = wr_cmd && wd[CMD_START] && !wd[CMD_STOP]
                      && run_mode_i != MODE_SYNC;
   assign cmd_stop = wr_cmd && wd[CMD_STOP] && !wd[CMD_START]
                     && run_mode_i != MODE_SYNC;

   always_ff @(posedge core_clk_i) begin
      if (rst) begin
         soft_rst_r <= 1'b0;
      end else begin
         soft_rst_r <= wr_cmd && wd[7:2] == RESET_KEY
                       && wd[CMD_START:CMD_STOP] == 2'b00;
      end
   end

   // ****************************************************************
   // status flags
   // ****************************************************************
   logic wire3_r;
   logic cs_caught_r;
   logic alv_r;
   logic rst_flag_r;
   logic map_err_r;
   logic int_err_r;
   logic sat_r;
   logic fresh_r;
   logic fresh_nxt;
   logic [7:0] map_check_r;
   logic conv_end;
   logic conv_begin;

   always_ff @(posedge core_clk_i) begin
      if (rst) begin
         cs_caught_r <= 1'b0;
         wire3_r <= 1'b0;
      end else if (!cs_caught_r) begin
         cs_caught_r <= 1'b1;
         wire3_r <= !cs_sync_r[1];
      end else if (cs_sync_r[1]) begin
         wire3_r <= 1'b0;
      end
   end

   // set wins over a clear written in the same cycle
   always_ff @(posedge core_clk_i) begin
      if (rst) begin
         alv_r <= ALV_RESET;
      end else if (alv_sync_r[1]) begin
         alv_r <= 1'b1;
      end else if (wr_flags && wd[FLAG_ALV]) begin
         alv_r <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst) begin
         rst_flag_r <= RST_FLAG_RESET;
      end else if (bo_sync_r[1] || reg_sync_r[1]) begin
         rst_flag_r <= 1'b1;
      end else if (wr_flags && wd[FLAG_RST]) begin
         rst_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst) begin
         link_err_r <= 1'b0;
      end else if (crc_ev && link_crc_en_i) begin
         link_err_r <= 1'b1;
      end else if (wr_flags && wd[FLAG_LINK]) begin
         link_err_r <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst) begin
         map_check_r <= '0;
      end else if (wr_ok && hold_r.addr == ADDR_MAP_CHECK) begin
         map_check_r <= wd;
      end
   end

   // disabling the check wins: nothing can set the flag while off
   always_ff @(posedge core_clk_i) begin
      if (rst || !map_crc_en_i) begin
         map_err_r <= 1'b0;
      end else if (map_check_r != map_crc_calc_i) begin
         map_err_r <= 1'b1;
      end else if (wr_flags && wd[FLAG_MAP]) begin
         map_err_r <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst) begin
         int_err_r <= 1'b0;
      end else if (int_sync_r[1]) begin
         int_err_r <= 1'b1;
      end
   end

   // ****************************************************************
   // conversion sequencer
   // ****************************************************************
   conv_state_t state_r;
   logic [7:0] cnt_r;
   logic stop_pend_r;
   logic sat_seen_r;
   logic cfg_hit;

   assign cfg_hit = wr_ok && hold_r.addr >= ADDR_CFG_LO
                    && hold_r.addr <= ADDR_CFG_HI;
   assign conv_end = state_r == CONV_RUN && cnt_r == CONV_CYCLES - 8'h01;
   // restart on start, or on config write only when already running
   assign conv_begin = cmd_start
                       || (cfg_hit && state_r == CONV_RUN);

   always_ff @(posedge core_clk_i) begin
      if (rst) begin
         state_r <= CONV_IDLE;
         cnt_r <= '0;
      end else if (conv_begin) begin
         state_r <= CONV_RUN;
         cnt_r <= '0;
      end else if (conv_end) begin
         cnt_r <= '0;
         if (run_mode_i == MODE_ONE_SHOT || stop_pend_r) begin
            state_r <= CONV_IDLE;
         end
      end else if (state_r == CONV_RUN) begin
         cnt_r <= cnt_r + 8'h01;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst || conv_begin || conv_end) begin
         stop_pend_r <= 1'b0;
      end else if (cmd_stop && state_r == CONV_RUN) begin
         stop_pend_r <= 1'b1;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst || conv_begin || conv_end) begin
         sat_seen_r <= 1'b0;
      end else if (mod_sat_i) begin
         sat_seen_r <= 1'b1;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst) begin
         sat_r <= 1'b0;
      end else if (conv_end) begin
         sat_r <= sat_seen_r || mod_sat_i;
      end
   end

   always_comb begin
      fresh_nxt = fresh_r;
      if (cmd_start && run_mode_i == MODE_ONE_SHOT) begin
         fresh_nxt = 1'b0;
      end else if (sample_read_i && run_mode_i != MODE_ONE_SHOT) begin
         fresh_nxt = 1'b0;
      end
      if (conv_end) begin
         fresh_nxt = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst) begin
         fresh_r <= 1'b0;
         new_sample_indicator_n_o <= 1'b1;
      end else begin
         fresh_r <= fresh_nxt;
         new_sample_indicator_n_o <= ~fresh_nxt;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst) begin
         converting_o <= 1'b0;
         conv_done_o <= 1'b0;
         sync_lost_o <= 1'b0;
         cfg_wr_o <= '0;
         cfg_wr_valid_o <= 1'b0;
      end else begin
         converting_o <= conv_begin || (state_r == CONV_RUN
                         && !(conv_end && (stop_pend_r
                         || run_mode_i == MODE_ONE_SHOT)));
         conv_done_o <= conv_end;
         sync_lost_o <= cfg_hit && state_r == CONV_RUN;
         cfg_wr_valid_o <= wr_ok && hold_r.addr >= ADDR_CFG_LO;
         cfg_wr_o <= req_ev ? '{write: 1'b1, addr: hold_r.addr, data: wd}
                     : cfg_wr_o;
      end
   end

   // ****************************************************************
   // read answer
   // ****************************************************************
   logic [7:0] flags;
   assign flags = {wire3_r, alv_r, rst_flag_r, link_err_r,
                   map_err_r, int_err_r, sat_r, fresh_r};

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         rdata_r <= '0;
         ack_tgl_r <= 1'b0;
      end else if (req_ev) begin
         ack_tgl_r <= ~ack_tgl_r;
         unique case (hold_r.addr)
            ADDR_IDENT: rdata_r <= DEVICE_IDENTIFIER;
            ADDR_REVISION: rdata_r <= DIE_REVISION;
            ADDR_FLAGS: rdata_r <= flags;
            ADDR_CMD: rdata_r <= 8'h00;
            default: rdata_r <= 8'h00;
         endcase
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   blocked_write_a: assert property (@(posedge core_clk_i)
      disable iff (rst)
      link_err_r && req_ev && hold_r.addr == ADDR_CMD && !conv_end
      |=> !soft_rst_r && $stable(state_r))
      else $error("write passed while link error set");
   link_err_gate_a: assert property (@(posedge core_clk_i)
      disable iff (rst)
      $rose(link_err_r) |-> $past(link_crc_en_i))
      else $error("link error set while checking off");
   map_clear_a: assert property (@(posedge core_clk_i)
      disable iff (srst_i)
      !map_crc_en_i |=> !map_err_r)
      else $error("map error survived disable");
   int_sticky_a: assert property (@(posedge core_clk_i)
      disable iff (rst)
      int_err_r && !rst |=> int_err_r)
      else $error("internal fault cleared without reset");
   pin_inverse_a: assert property (@(posedge core_clk_i)
      disable iff (srst_i)
      new_sample_indicator_n_o == !fresh_r)
      else $error("pin and new-data bit disagree");
   key_reset_a: assert property (@(posedge core_clk_i)
      disable iff (srst_i)
      wr_cmd && wd == {RESET_KEY, 2'b00} |=> soft_rst_r
      ##1 alv_r && rst_flag_r)
      else $error("reset key did not reset");
   sync_ignore_a: assert property (@(posedge core_clk_i)
      disable iff (rst)
      wr_cmd && run_mode_i == MODE_SYNC && state_r == CONV_IDLE
      |=> state_r == CONV_IDLE)
      else $error("command acted in synchronized mode");
   stop_complete_a: assert property (@(posedge core_clk_i)
      disable iff (rst)
      cmd_stop && state_r == CONV_RUN && !conv_end && !conv_begin
      |=> state_r == CONV_RUN)
      else $error("stop cut conversion short");
   idle_cfg_a: assert property (@(posedge core_clk_i)
      disable iff (rst)
      cfg_hit && state_r == CONV_IDLE && !cmd_start
      |=> state_r == CONV_IDLE [*2])
      else $error("config write started idle converter");
   oneshot_hold_a: assert property (@(posedge core_clk_i)
      disable iff (rst)
      fresh_r && run_mode_i == MODE_ONE_SHOT && !cmd_start
      && $stable(run_mode_i) |=> fresh_r)
      else $error("one-shot new-data bit dropped early");

endmodule : adc_status_control_regs

`default_nettype wire

// file: verif/link_host_model.sv
/*
 * Host model: issues one register access at a time on the link.
 * Assumes the bank answers each request with a link_done_o pulse.
 */
`default_nettype none

module link_host_model
   import adc_regs_pkg::*;
(
   // link clock
   input wire logic link_clk_i,
   // answer from the bank
   input wire logic done_i,
   input wire logic [7:0] rdata_i,
   // request to the bank
   output var adc_regs_pkg::link_req_t req_o
);
   timeunit 1ns;
   timeprecision 1ps;

   initial req_o = '0;

   // ****************************************************************
   // one access, answer taken at the done edge
   // ****************************************************************
   task automatic access(input logic w, input logic [3:0] a,
      input logic [7:0] d, output logic [7:0] q, output bit ok);
      ok = 1'b0;
      q = 8'h00;
      @(posedge link_clk_i);
      req_o <= '{1'b1, w, a, d};
      @(posedge link_clk_i);
      // idle lines inverted so stale values never pass
      req_o <= '{1'b0, ~w, ~a, ~d};
      for (int i = 0; i < 60 && !ok; i++) begin
         @(posedge link_clk_i);
         if (done_i === 1'b1) begin
            ok = 1'b1;
            q = rdata_i;
         end
      end
   endtask : access

endmodule : link_host_model

`default_nettype wire

// file: verif/adc_status_control_regs_tb.sv
/*
 * Self-checking bench of the status and run-command bank.
 * Assumes the link host model and the design package are compiled first.
 */
`default_nettype none

module adc_status_control_regs_tb;
   import adc_regs_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic core_clk_i = 1'b0, link_clk_i = 1'b0, srst_i = 1'b1;
   logic link_crc_err_i = 1'b0, cs_n_i = 1'b1, mod_sat_i = 1'b0;
   logic link_crc_en_i = 1'b0, map_crc_en_i = 1'b0, sample_read_i = 1'b0;
   logic [3:0] mon_v = 4'h0;
   logic [7:0] map_crc_calc_i = 8'h00;
   run_mode_t run_mode_i = MODE_START_STOP;
   link_req_t link_req_i;
   logic link_busy_o, link_done_o, new_sample_indicator_n_o;
   logic converting_o, conv_done_o, sync_lost_o, cfg_wr_valid_o;
   logic [7:0] link_rdata_o, q, model_flags;
   cfg_wr_t cfg_wr_o, cfg_last;
   logic [7:0] rnd;
   logic [7:0] keys [3] = '{8'h5b, 8'h59, 8'h54};
   int fail_count = 0, check_count = 0, cyc_cnt = 0;
   int cfg_seen = 0, sync_seen = 0, t0, t1;
   int seed = 32'h9ad691ce;
   bit ok;

   initial forever #20 core_clk_i = ~core_clk_i;
   initial begin
      #3;
      forever #6 link_clk_i = ~link_clk_i;
   end

   always @(posedge core_clk_i) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cfg_wr_valid_o === 1'b1) begin
         cfg_seen <= cfg_seen + 1;
         cfg_last <= cfg_wr_o;
      end
      if (sync_lost_o === 1'b1)
         sync_seen <= sync_seen + 1;
   end

   adc_status_control_regs u_adc_status_control_regs (
      .core_clk_i, .srst_i, .link_clk_i, .link_req_i, .link_crc_err_i,
      .link_busy_o, .link_done_o, .link_rdata_o, .cs_n_i,
      .analog_low_i(mon_v[0]), .io_brownout_i(mon_v[1]),
      .regulator_fault_i(mon_v[2]), .internal_fault_i(mon_v[3]),
      .run_mode_i, .link_crc_en_i, .map_crc_en_i, .map_crc_calc_i,
      .mod_sat_i, .sample_read_i, .new_sample_indicator_n_o,
      .converting_o, .conv_done_o, .sync_lost_o, .cfg_wr_o,
      .cfg_wr_valid_o);

   link_host_model u_link_host_model (.link_clk_i, .done_i(link_done_o),
      .rdata_i(link_rdata_o), .req_o(link_req_i));

   // ****************************************************************
   // helpers
   // ****************************************************************
   task automatic check(input logic [7:0] seen, input logic [7:0] expv);
      check_count++;
      if (seen !== expv) begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h",
            $time, seen, expv);
      end
   endtask : check

   task automatic results();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : results

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask : cyc

   task automatic xfer(input logic w, input logic [3:0] a,
      input logic [7:0] d);
      u_link_host_model.access(w, a, d, q, ok);
      if (!ok) begin
         fail_count++;
         results();
      end
   endtask : xfer

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      xfer(1'b1, a, d);
      cyc(4);
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      xfer(1'b0, a, 8'h00);
      check(q, e);
   endtask : rd

   // status model against bits 7:1, bit 0 against the pin
   task automatic flags_chk();
      xfer(1'b0, ADDR_FLAGS, 8'h00);
      check({1'b0, q[7:1]}, {1'b0, model_flags[7:1]});
      check({7'h00, q[0]}, {7'h00, ~new_sample_indicator_n_o});
   endtask : flags_chk

   task automatic mon(input int k);
      @(posedge core_clk_i);
      mon_v[k] <= 1'b1;
      cyc(3);
      mon_v <= 4'h0;
      cyc(4);
   endtask : mon

   task automatic wait_done(output int t);
      t = -1;
      for (int i = 0; i < 300 && t < 0; i++) begin
         @(posedge core_clk_i);
         #1;
         if (conv_done_o === 1'b1)
            t = cyc_cnt;
      end
      if (t < 0) begin
         fail_count++;
         results();
      end
   endtask : wait_done

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      cyc(10);
      srst_i <= 1'b0;
      cyc(4);
      model_flags = 8'h60;
      rd(ADDR_IDENT, DEVICE_IDENTIFIER);
      rd(ADDR_REVISION, DIE_REVISION);
      rd(ADDR_CMD, 8'h00);
      flags_chk();
      wr(ADDR_FLAGS, 8'h00);
      flags_chk();
      wr(ADDR_FLAGS, 8'hff);
      model_flags = 8'h00;
      flags_chk();
      mon(0);
      model_flags = 8'h40;
      flags_chk();
      wr(ADDR_FLAGS, 8'h40);
      for (int k = 1; k < 3; k++) begin
         mon(k);
         model_flags = 8'h20;
         flags_chk();
         wr(ADDR_FLAGS, 8'h20);
      end
      model_flags = 8'h00;
      @(posedge link_clk_i);
      link_crc_err_i <= 1'b1;
      @(posedge link_clk_i);
      link_crc_err_i <= 1'b0;
      cyc(4);
      flags_chk();
      @(posedge core_clk_i);
      link_crc_en_i <= 1'b1;
      cyc(3);
      @(posedge link_clk_i);
      link_crc_err_i <= 1'b1;
      @(posedge link_clk_i);
      link_crc_err_i <= 1'b0;
      cyc(4);
      model_flags = 8'h10;
      flags_chk();
      wr(ADDR_CMD, 8'h02);
      check({7'h00, converting_o}, 8'h00);
      wr(ADDR_FLAGS, 8'h10);
      model_flags = 8'h00;
      flags_chk();
      @(posedge core_clk_i);
      link_crc_en_i <= 1'b0;
      map_crc_calc_i <= 8'($random(seed));
      cyc(1);
      wr(ADDR_MAP_CHECK, map_crc_calc_i ^ 8'h01);
      map_crc_en_i <= 1'b1;
      cyc(4);
      model_flags = 8'h08;
      flags_chk();
      map_crc_en_i <= 1'b0;
      cyc(4);
      model_flags = 8'h00;
      flags_chk();
      wr(ADDR_MAP_CHECK, map_crc_calc_i);
      map_crc_en_i <= 1'b1;
      cyc(4);
      flags_chk();
      map_crc_en_i <= 1'b0;
      mon(3);
      model_flags = 8'h04;
      wr(ADDR_FLAGS, 8'hff);
      flags_chk();
      foreach (keys[i]) begin
         wr(ADDR_CMD, keys[i]);
         flags_chk();
         check({7'h00, converting_o}, 8'h00);
      end
      wr(ADDR_CMD, {RESET_KEY, 2'b00});
      cyc(4);
      model_flags = 8'h60;
      flags_chk();
      wr(ADDR_FLAGS, 8'h60);
      run_mode_i <= MODE_SYNC;
      wr(ADDR_CMD, 8'h00);
      wr(ADDR_CMD, 8'h02);
      check({7'h00, converting_o}, 8'h00);
      run_mode_i <= MODE_START_STOP;
      t0 = cfg_seen;
      rnd = 8'($random(seed));
      wr(ADDR_CFG_LO, rnd);
      check({7'h00, converting_o}, 8'h00);
      check(8'(cfg_seen - t0), 8'h01);
      check(cfg_last.data, rnd);
      check({4'h0, cfg_last.addr}, {4'h0, ADDR_CFG_LO});
      // one-shot, with saturation inside the conversion
      run_mode_i <= MODE_ONE_SHOT;
      mod_sat_i <= 1'b1;
      wr(ADDR_CMD, 8'h00);
      wr(ADDR_CMD, 8'h02);
      check({7'h00, converting_o}, 8'h01);
      mod_sat_i <= 1'b0;
      wait_done(t0);
      cyc(2);
      check({7'h00, converting_o}, 8'h00);
      model_flags = 8'h02;
      flags_chk();
      sample_read_i <= 1'b1;
      cyc(1);
      sample_read_i <= 1'b0;
      cyc(3);
      check({7'h00, new_sample_indicator_n_o}, 8'h00);
      wr(ADDR_CMD, 8'h02);
      check({7'h00, new_sample_indicator_n_o}, 8'h01);
      wait_done(t0);
      cyc(2);
      model_flags = 8'h00;
      flags_chk();
      // start/stop: continuous, reconfig, restart, stop
      run_mode_i <= MODE_START_STOP;
      wr(ADDR_CMD, 8'h00);
      wr(ADDR_CMD, 8'h02);
      wait_done(t0);
      wait_done(t1);
      check(8'(t1 - t0 >= int'(CONV_CYCLES)), 8'h01);
      check({7'h00, converting_o}, 8'h01);
      t0 = sync_seen;
      wr(4'h5, 8'($random(seed)));
      check(8'(sync_seen - t0), 8'h01);
      wait_done(t0);
      cyc(20);
      wr(ADDR_CMD, 8'h02);
      wait_done(t1);
      check(8'(t1 - t0 > int'(CONV_CYCLES) + 20), 8'h01);
      wr(ADDR_CMD, 8'h01);
      check({7'h00, converting_o}, 8'h01);
      wait_done(t0);
      cyc(2);
      check({7'h00, converting_o}, 8'h00);
      rd(ADDR_CMD, 8'h00);
      // reset with chip select held low
      cs_n_i <= 1'b0;
      srst_i <= 1'b1;
      cyc(10);
      srst_i <= 1'b0;
      cyc(4);
      model_flags = 8'he0;
      flags_chk();
      cs_n_i <= 1'b1;
      cyc(4);
      model_flags = 8'h60;
      flags_chk();
      results();
   end

endmodule : adc_status_control_regs_tb

`default_nettype wire
